//--- core/fpt_defines.vh
`ifndef FPT_DEFINES_VH
`define FPT_DEFINES_VH
// ************************************************************
// Register offsets
// ************************************************************
`define FPT_ADDR_PRESENCE 8'h03
`define FPT_ADDR_ALARM 8'h07
`define FPT_ADDR_FULL 8'h09
`define FPT_ADDR_SPINUP 8'h0c
`define FPT_ADDR_CFG1 8'h68
`define FPT_ADDR_CFG2 8'h69
`define FPT_ADDR_TACH1 8'h70
`define FPT_ADDR_TACH2 8'h71
`define FPT_ADDR_LIM1 8'h78
`define FPT_ADDR_LIM2 8'h79
`define FPT_ADDR_IRQ_STAT 8'hf0
`define FPT_ADDR_IRQ_MASK 8'hf1
`define FPT_ADDR_DUTY 8'hf2
// ************************************************************
// Reset values
// ************************************************************
`define FPT_RST_ALARM 8'h00
`define FPT_RST_FULL 8'h00
`define FPT_RST_SPINUP 4'h3
`define FPT_RST_CFG 8'h2f
`define FPT_RST_TACH 8'h00
`define FPT_RST_LIM 8'hff
`define FPT_RST_DUTY 4'h8
// ************************************************************
// Field positions
// ************************************************************
`define FPT_SPIN_DIS_BIT 3
`define FPT_CFG_HP_MSB 3
`define FPT_CFG_HP_LSB 0
`define FPT_CFG_PWM_MSB 5
`define FPT_CFG_PWM_LSB 4
`define FPT_CFG_OSC_MSB 7
`define FPT_CFG_OSC_LSB 6
// ************************************************************
// Timing (clock 250 MHz)
// ************************************************************
`define FPT_CLK_HZ 250000000
// PWM has 16 slots per period: slot rate = freq * 16
`define FPT_PWM_SLOT_HZ0 250
`define FPT_PWM_SLOT_HZ1 1000
`define FPT_PWM_SLOT_HZ2 4000
`define FPT_PWM_SLOT_HZ3 16000
`define FPT_OSC_HZ1 470
`define FPT_OSC_HZ2 940
`define FPT_OSC_HZ3 1880
`define FPT_SPIN_S0 5'd16
`define FPT_SPIN_S1 5'd8
`define FPT_SPIN_S2 5'd4
`endif

//--- core/fpt_divider.v
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Programmable tick divider: one-cycle pulse every i_period
// ************************************************************
module fpt_divider #(
   parameter WIDTH = 24
) (
   // Clock and reset
   input wire i_clk,
   input wire i_reset,
   // Control
   input wire i_en,
   input wire [WIDTH-1:0] i_period,
   // Tick
   output wire o_tick
);
   reg [WIDTH-1:0] cnt_ff;
   wire wrap = (cnt_ff >= i_period - {{(WIDTH-1){1'b0}}, 1'b1});
   assign o_tick = i_en & wrap;
   always @(posedge i_clk) begin
      if (i_reset || !i_en || wrap) begin
         cnt_ff <= {WIDTH{1'b0}};
      end else begin
         cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule // fpt_divider
`default_nettype wire

//--- core/fpt_fan_channel.v
`timescale 1ns/1ps
`include "fpt_defines.vh"
`default_nettype none
// ************************************************************
// One fan: PWM output and tach period measurement
// ************************************************************
module fpt_fan_channel (
   // Clock and reset
   input wire i_clk,
   input wire i_reset,
   // Control
   input wire [7:0] i_cfg,
   input wire [3:0] i_duty,
   input wire [7:0] i_limit,
   input wire i_tach_sync,
   // Results
   output wire o_pwm,
   output reg [7:0] o_tach,
   output wire o_slow_pulse
);
   // Full integer width here, cut to the divider width where used
   localparam [31:0] PWM_P0 = `FPT_CLK_HZ / `FPT_PWM_SLOT_HZ0;
   localparam [31:0] PWM_P1 = `FPT_CLK_HZ / `FPT_PWM_SLOT_HZ1;
   localparam [31:0] PWM_P2 = `FPT_CLK_HZ / `FPT_PWM_SLOT_HZ2;
   localparam [31:0] PWM_P3 = `FPT_CLK_HZ / `FPT_PWM_SLOT_HZ3;
   localparam [31:0] OSC_P1 = `FPT_CLK_HZ / `FPT_OSC_HZ1;
   localparam [31:0] OSC_P2 = `FPT_CLK_HZ / `FPT_OSC_HZ2;
   localparam [31:0] OSC_P3 = `FPT_CLK_HZ / `FPT_OSC_HZ3;
   wire [1:0] pwm_sel = i_cfg[`FPT_CFG_PWM_MSB:`FPT_CFG_PWM_LSB];
   wire [1:0] osc_sel = i_cfg[`FPT_CFG_OSC_MSB:`FPT_CFG_OSC_LSB];
   reg [23:0] pwm_period;
   reg [23:0] osc_period;
   wire slot_tick;
   wire osc_tick;
   reg [3:0] slot_ff;
   reg pwm_ff;
   reg tach_d_ff;
   reg [7:0] cnt_ff;
   reg slow_ff;
   wire osc_on = (osc_sel != 2'b00);
   wire tach_edge = i_tach_sync & ~tach_d_ff;

   always @* begin
      case (pwm_sel)
         2'b00: pwm_period = PWM_P0[23:0];
         2'b01: pwm_period = PWM_P1[23:0];
         2'b10: pwm_period = PWM_P2[23:0];
         default: pwm_period = PWM_P3[23:0];
      endcase
      case (osc_sel)
         2'b01: osc_period = OSC_P1[23:0];
         2'b10: osc_period = OSC_P2[23:0];
         default: osc_period = OSC_P3[23:0];
      endcase
   end

   fpt_divider #(.WIDTH(24)) u_pwm_div (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_en(1'b1),
      .i_period(pwm_period),
      .o_tick(slot_tick)
   );
   fpt_divider #(.WIDTH(24)) u_osc_div (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_en(osc_on),
      .i_period(osc_period),
      .o_tick(osc_tick)
   );

   // ************************************************************
   // PWM: duty 15 means always on
   // ************************************************************
   always @(posedge i_clk) begin
      if (i_reset) begin
         slot_ff <= 4'h0;
         pwm_ff <= 1'b0;
      end else begin
         if (slot_tick) begin
            slot_ff <= slot_ff + 4'h1;
         end
         pwm_ff <= (i_duty == 4'hf) || (slot_ff < i_duty);
      end
   end
   assign o_pwm = pwm_ff;

   // ************************************************************
   // Tach: count oscillator ticks between rising tach edges
   // ************************************************************
   always @(posedge i_clk) begin
      if (i_reset) begin
         tach_d_ff <= 1'b0;
         cnt_ff <= 8'h00;
         o_tach <= `FPT_RST_TACH;
         slow_ff <= 1'b0;
      end else begin
         tach_d_ff <= i_tach_sync;
         slow_ff <= 1'b0;
         if (!osc_on) begin
            cnt_ff <= 8'h00;
         end else if (tach_edge) begin
            o_tach <= cnt_ff;
            slow_ff <= (cnt_ff > i_limit);
            cnt_ff <= 8'h00;
         end else if (osc_tick && cnt_ff != 8'hff) begin
            // Saturate so a stopped fan reads full scale unless the limit is ff
            cnt_ff <= cnt_ff + 8'h01;
         end else if (osc_tick && i_limit != 8'hff) begin
            // No edges at all: stopped fan still flagged unless the limit is ff
            o_tach <= 8'hff;
            slow_ff <= 1'b1;
         end
      end
   end
   assign o_slow_pulse = slow_ff;
endmodule // fpt_fan_channel
`default_nettype wire

//--- core/fpt_top.v
// Operation
// - Fan-one presence bit resets to one
// - Fan-two presence loaded from install pin
// - Reserved bits read as zero
// - Alarm override bit forces alarm speed
// - Full override bit forces full speed
// - Spin-up disable skips full-speed start phase
// - Spin-up time codes: 16, 8, 4 s
// - Removed fan sets others to hot-plug speed
// - Installed fan runs at normal speed
// - PWM frequency select 15.625 to 1000 Hz
// - Tach oscillator select, 00 disables measurement
// - Tach count register read-only, resets zero
// - Count oscillator cycles between tach pulses
// - Count above limit flags slow fan
`timescale 1ns/1ps
`include "fpt_defines.vh"
`default_nettype none
module fpt_top #(
   parameter [3:0] ALARM_DUTY = 4'hc,
   parameter [3:0] FULL_DUTY = 4'hf,
   // Seconds are long: a simulation may shorten this
   parameter [27:0] SEC_CYCLES = `FPT_CLK_HZ
) (
   // Clock and reset
   input wire I_CLK,
   input wire I_RESET,
   // Register port
   input wire [7:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [7:0] O_RDATA,
   // Fan pins
   input wire I_INSTALL_SENSE_PIN,
   input wire [1:0] I_TACH,
   output wire [1:0] O_PWM,
   // Interrupt
   output wire O_IRQ
);
   // ************************************************************
   // Declarations
   // ************************************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SPIN = 3'b010;
   localparam [2:0] ST_RUN = 3'b100;

   reg [1:0] present_ff;
   reg [1:0] alarm_ff;
   reg [1:0] full_ff;
   reg [3:0] spinup_ff;
   reg [7:0] cfg_ff [0:1];
   reg [7:0] lim_ff [0:1];
   reg [3:0] duty_ff;
   reg [3:0] irq_stat_ff;
   reg [3:0] irq_mask_ff;
   reg [1:0] inst_s1_ff;
   reg [1:0] inst_s2_ff;
   reg [1:0] tach_s1_ff;
   reg [1:0] tach_s2_ff;
   reg [1:0] inst_d_ff;
   reg strap_done_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [27:0] sec_cnt_ff;
   reg [4:0] spin_elapsed_ff;
   reg [4:0] nxt_spin_elapsed;
   reg [4:0] spin_secs;
   reg [1:0] removed_ff;
   wire [7:0] tach_val [0:1];
   wire [1:0] slow_pulse;
   wire [1:0] hp_pulse;
   wire [3:0] irq_events;
   wire sec_tick = (sec_cnt_ff == SEC_CYCLES - 28'h1);
   wire spinning = (state_ff == ST_SPIN);
   reg [3:0] hp_duty;
   genvar g;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         inst_s1_ff <= 2'b00;
         inst_s2_ff <= 2'b00;
         tach_s1_ff <= 2'b00;
         tach_s2_ff <= 2'b00;
      end else begin
         // Bit 0 carries a one through both stages to mark them filled
         inst_s1_ff <= {I_INSTALL_SENSE_PIN, 1'b1};
         inst_s2_ff <= inst_s1_ff;
         tach_s1_ff <= I_TACH;
         tach_s2_ff <= tach_s1_ff;
      end
   end
   // Synchronised install sense is inst_s2_ff[1]
   wire install_lvl = inst_s2_ff[1];

   // ************************************************************
   // Registers
   // ************************************************************
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         present_ff <= 2'b01;
         strap_done_ff <= 1'b0;
         alarm_ff <= 2'b00;
         full_ff <= 2'b00;
         spinup_ff <= `FPT_RST_SPINUP;
         cfg_ff[0] <= `FPT_RST_CFG;
         cfg_ff[1] <= `FPT_RST_CFG;
         lim_ff[0] <= `FPT_RST_LIM;
         lim_ff[1] <= `FPT_RST_LIM;
         duty_ff <= `FPT_RST_DUTY;
         irq_mask_ff <= 4'h0;
      end else begin
         // Strap is caught once the synchroniser has filled
         if (!strap_done_ff && inst_s2_ff[0]) begin
            strap_done_ff <= 1'b1;
            present_ff[1] <= install_lvl;
         end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b0;
         end
         if (I_WR) begin
            if (I_ADDR == `FPT_ADDR_PRESENCE) begin
               present_ff <= I_WDATA[1:0];
            end else if (I_ADDR == `FPT_ADDR_ALARM) begin
               alarm_ff <= I_WDATA[1:0];
            end else if (I_ADDR == `FPT_ADDR_FULL) begin
               full_ff <= I_WDATA[1:0];
            end else if (I_ADDR == `FPT_ADDR_SPINUP) begin
               spinup_ff <= I_WDATA[3:0];
            end else if (I_ADDR == `FPT_ADDR_CFG1) begin
               cfg_ff[0] <= I_WDATA;
            end else if (I_ADDR == `FPT_ADDR_CFG2) begin
               cfg_ff[1] <= I_WDATA;
            end else if (I_ADDR == `FPT_ADDR_LIM1) begin
               lim_ff[0] <= I_WDATA;
            end else if (I_ADDR == `FPT_ADDR_LIM2) begin
               lim_ff[1] <= I_WDATA;
            end else if (I_ADDR == `FPT_ADDR_IRQ_MASK) begin
               irq_mask_ff <= I_WDATA[3:0];
            end else if (I_ADDR == `FPT_ADDR_DUTY) begin
               duty_ff <= I_WDATA[3:0];
            end
         end
      end
   end

   // Presence one cycle back, to see a fan being removed
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         inst_d_ff <= 2'b00;
      end else begin
         inst_d_ff <= present_ff;
      end
   end

   // ************************************************************
   // Interrupt status: set wins over write-one-to-clear
   // ************************************************************
   assign irq_events = {hp_pulse, slow_pulse};
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         irq_stat_ff <= 4'h0;
      end else if (I_WR && I_ADDR == `FPT_ADDR_IRQ_STAT) begin
         irq_stat_ff <= (irq_stat_ff & ~I_WDATA[3:0]) | irq_events;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_events;
      end
   end
   assign O_IRQ = |(irq_stat_ff & irq_mask_ff);

   // ************************************************************
   // Read port
   // ************************************************************
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         O_RDATA <= 8'h00;
      end else if (!I_RD) begin
         O_RDATA <= 8'h00;
      end else if (I_ADDR == `FPT_ADDR_PRESENCE) begin
         O_RDATA <= {6'h00, present_ff};
      end else if (I_ADDR == `FPT_ADDR_ALARM) begin
         O_RDATA <= {6'h00, alarm_ff};
      end else if (I_ADDR == `FPT_ADDR_FULL) begin
         O_RDATA <= {6'h00, full_ff};
      end else if (I_ADDR == `FPT_ADDR_SPINUP) begin
         O_RDATA <= {4'h0, spinup_ff};
      end else if (I_ADDR == `FPT_ADDR_CFG1) begin
         O_RDATA <= cfg_ff[0];
      end else if (I_ADDR == `FPT_ADDR_CFG2) begin
         O_RDATA <= cfg_ff[1];
      end else if (I_ADDR == `FPT_ADDR_TACH1) begin
         O_RDATA <= tach_val[0];
      end else if (I_ADDR == `FPT_ADDR_TACH2) begin
         O_RDATA <= tach_val[1];
      end else if (I_ADDR == `FPT_ADDR_LIM1) begin
         O_RDATA <= lim_ff[0];
      end else if (I_ADDR == `FPT_ADDR_LIM2) begin
         O_RDATA <= lim_ff[1];
      end else if (I_ADDR == `FPT_ADDR_IRQ_STAT) begin
         O_RDATA <= {4'h0, irq_stat_ff};
      end else if (I_ADDR == `FPT_ADDR_IRQ_MASK) begin
         O_RDATA <= {4'h0, irq_mask_ff};
      end else if (I_ADDR == `FPT_ADDR_DUTY) begin
         O_RDATA <= {4'h0, duty_ff};
      end else begin
         O_RDATA <= 8'h00;
      end
   end

   // ************************************************************
   // Spin-up sequencer
   // ************************************************************
   always @* begin
      case (spinup_ff[2:0])
         3'b000: spin_secs = `FPT_SPIN_S0;
         3'b001: spin_secs = `FPT_SPIN_S1;
         default: spin_secs = `FPT_SPIN_S2;
      endcase
   end

   always @* begin
      nxt_state = state_ff;
      nxt_spin_elapsed = spin_elapsed_ff;
      case (state_ff)
         ST_IDLE: begin
            nxt_spin_elapsed = 5'd0;
            if (spinup_ff[`FPT_SPIN_DIS_BIT]) begin
               nxt_state = ST_RUN;
            end else begin
               nxt_state = ST_SPIN;
            end
         end
         ST_SPIN: begin
            // Compared live, so a time code written during spin-up counts
            if (spinup_ff[`FPT_SPIN_DIS_BIT]) begin
               nxt_state = ST_RUN;
            end else if (sec_tick) begin
               if (spin_elapsed_ff + 5'd1 >= spin_secs) begin
                  nxt_state = ST_RUN;
               end
               nxt_spin_elapsed = spin_elapsed_ff + 5'd1;
            end
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   always @(posedge I_CLK) begin
      if (I_RESET) begin
         state_ff <= ST_IDLE;
         spin_elapsed_ff <= 5'd0;
         sec_cnt_ff <= 28'h0;
      end else begin
         state_ff <= nxt_state;
         spin_elapsed_ff <= nxt_spin_elapsed;
         if (!spinning || sec_tick) begin
            sec_cnt_ff <= 28'h0;
         end else begin
            sec_cnt_ff <= sec_cnt_ff + 28'h1;
         end
      end
   end

   // ************************************************************
   // Hot-plug tracking: removal is a presence bit falling
   // ************************************************************
   always @(posedge I_CLK) begin
      if (I_RESET) begin
         removed_ff <= 2'b00;
      end else begin
         // Reinstall clears removal so the other fan goes back to normal
         removed_ff <= (removed_ff | hp_pulse) & ~present_ff;
      end
   end
   assign hp_pulse = inst_d_ff & ~present_ff;

   always @* begin
      // Use the removed fan's hot-plug nibble, fan one first
      if (removed_ff[0]) begin
         hp_duty = cfg_ff[0][`FPT_CFG_HP_MSB:`FPT_CFG_HP_LSB];
      end else begin
         hp_duty = cfg_ff[1][`FPT_CFG_HP_MSB:`FPT_CFG_HP_LSB];
      end
   end

   // ************************************************************
   // Fan channels
   // ************************************************************
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_fan
         reg [3:0] duty;
         always @* begin
            if (full_ff[g] || spinning) begin
               duty = FULL_DUTY;
            end else if (alarm_ff[g]) begin
               duty = ALARM_DUTY;
            end else if (|(removed_ff & ~(2'b01 << g))) begin
               duty = hp_duty;
            end else begin
               duty = duty_ff;
            end
         end
         fpt_fan_channel u_chan (
            .i_clk(I_CLK),
            .i_reset(I_RESET),
            .i_cfg(cfg_ff[g]),
            .i_duty(present_ff[g] ? duty : 4'h0),
            .i_limit(lim_ff[g]),
            .i_tach_sync(tach_s2_ff[g]),
            .o_pwm(O_PWM[g]),
            .o_tach(tach_val[g]),
            .o_slow_pulse(slow_pulse[g])
         );
      end
   endgenerate
endmodule // fpt_top
`default_nettype wire

//--- test/fpt_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Two cooling fans: tach edges while driven
// ************************************************************
module fpt_fan_model #(
   parameter int HALF = 20
) (
   // Clock
   input wire logic i_clk,
   // Fan drive and sensor
   input wire logic [1:0] i_pwm,
   output var logic [1:0] o_tach
);
   int cnt [2];

   initial o_tach = 2'b00;
   initial cnt = '{0, 0};

   // A rotor only turns while driven; a stopped one leaves its sensor put
   always @(posedge i_clk) begin
      for (int f = 0; f < 2; f++) begin
         if (i_pwm[f]) begin
            cnt[f] <= (cnt[f] == HALF - 1) ? 0 : cnt[f] + 1;
            if (cnt[f] == HALF - 1) o_tach[f] <= ~o_tach[f];
         end
      end
   end
endmodule // fpt_fan_model
`default_nettype wire

//--- test/fpt_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker of the fan block
// ************************************************************
module fpt_top_chk #(
   parameter [3:0] ALARM_DUTY = 4'hc
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET,
   // Register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   // Fan pins and interrupt
   input wire logic I_INSTALL_SENSE_PIN,
   input wire logic [1:0] I_TACH,
   input wire logic [1:0] O_PWM,
   input wire logic O_IRQ
);
   // Shadow of the few writable bits the properties depend on
   logic [7:0] lim_ff;
   logic [3:0] mask_ff;
   logic pres_ff, full_ff, alarm_ff, spdis_ff;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   always @(posedge I_CLK) begin
      if (I_RESET) begin
         lim_ff <= 8'hff;
         mask_ff <= 4'h0;
         pres_ff <= 1'b1;
         full_ff <= 1'b0;
         alarm_ff <= 1'b0;
         spdis_ff <= 1'b0;
      end else if (I_WR) begin
         case (I_ADDR)
            8'h03: pres_ff <= I_WDATA[0];
            8'h07: alarm_ff <= I_WDATA[0];
            8'h09: full_ff <= I_WDATA[0];
            8'h0c: spdis_ff <= I_WDATA[3];
            8'h78: lim_ff <= I_WDATA;
            8'hf1: mask_ff <= I_WDATA[3:0];
            default: ;
         endcase
      end
   end

   chk_pres_bit: assert property (
      I_RD && I_ADDR == 8'h03 |=> O_RDATA[0] == $past(pres_ff))
      else $error("fan one presence bit wrong");
   chk_pres_rsvd: assert property (
      I_RD && I_ADDR == 8'h03 |=> O_RDATA[7:2] == 6'h00)
      else $error("presence reserved bits not zero");
   chk_force_rsvd: assert property (
      I_RD && (I_ADDR == 8'h07 || I_ADDR == 8'h09)
      |=> O_RDATA[7:2] == 6'h00)
      else $error("override reserved bits not zero");
   chk_spin_rsvd: assert property (
      I_RD && I_ADDR == 8'h0c |=> O_RDATA[7:4] == 4'h0)
      else $error("spin-up reserved bits not zero");
   chk_lim_rw: assert property (
      I_RD && I_ADDR == 8'h78 |=> O_RDATA == $past(lim_ff))
      else $error("tach limit readback wrong");
   chk_full_pwm: assert property (
      (full_ff && pres_ff) [*8] |-> O_PWM[0])
      else $error("full override not driving fan one");
   chk_alarm_pwm: assert property (
      (ALARM_DUTY == 4'h0 && alarm_ff && !full_ff && pres_ff && spdis_ff)
      [*8] |-> !O_PWM[0])
      else $error("alarm override not applied to fan one");
   chk_irq_remove: assert property (
      I_WR && I_ADDR == 8'h03 && !I_WDATA[0] && pres_ff && mask_ff[2]
      |-> ##[1:4] O_IRQ)
      else $error("fan one removal raised no interrupt");
   chk_irq_masked: assert property (
      (mask_ff == 4'h0) [*2] |-> !O_IRQ)
      else $error("interrupt high with all sources masked");
   chk_rd_idle: assert property (
      !$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data not zero outside read answer");

   cov_lim_read: cover property (I_RD && I_ADDR == 8'h78);
   cov_full_drive: cover property (full_ff && O_PWM[0]);
   cov_remove: cover property (I_WR && I_ADDR == 8'h03 && !I_WDATA[0]
      && pres_ff && mask_ff[2]);
endmodule // fpt_top_chk

bind fpt_top fpt_top_chk #(.ALARM_DUTY(ALARM_DUTY)) u_chk (
   .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_INSTALL_SENSE_PIN(I_INSTALL_SENSE_PIN), .I_TACH(I_TACH),
   .O_PWM(O_PWM), .O_IRQ(O_IRQ));
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register and fan drive bench
// ************************************************************
module tb;
   logic clk, rst, wr_s, rd_s, pin, rd_d, irq;
   logic [7:0] addr, wdata, rdata, d;
   logic [1:0] tach, pwm;
   logic [7:0] expq [$];
   logic [31:0] seed = 32'h4;
   int errors = 0;
   int n_tests = 0;
   int i;
   logic [7:0] ra [10] = '{8'h07, 8'h09, 8'h0c, 8'h68, 8'h69,
      8'h70, 8'h71, 8'h78, 8'h79, 8'h55};
   logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h03, 8'h2f, 8'h2f,
      8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
   logic [7:0] wa [4] = '{8'h03, 8'h07, 8'h09, 8'h0c};

   // One second shortened to 100 cycles so every spin-up code fits the run
   fpt_top #(.ALARM_DUTY(4'h0), .FULL_DUTY(4'hf), .SEC_CYCLES(28'd100))
   u_fpt_top (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
      .I_INSTALL_SENSE_PIN(pin), .I_TACH(tach), .O_PWM(pwm),
      .O_IRQ(irq));
   fpt_fan_model #(.HALF(20)) u_fpt_fan_model (.i_clk(clk),
      .i_pwm(pwm), .o_tach(tach));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task stop_test();
      $display("checks=%0d errors=%0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      expq.push_back(e);
      @(posedge clk);
      rd_s <= 1'b0;
   endtask

   // Level of fan f (2 means the interrupt) must settle to e
   task lvl_is(input int f, input logic e);
      logic v;
      v = ~e;
      for (int k = 0; k < 40 && v !== e; k++) begin
         @(negedge clk);
         v = (f == 2) ? irq : pwm[f];
      end
      check({7'h00, v}, {7'h00, e});
   endtask

   task do_reset();
      d = 8'(rnd());
      @(posedge clk);
      rst <= 1'b1;
      pin <= d[0];
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   // Read answers are compared one cycle after their strobe
   always @(posedge clk) begin
      if (rd_d) check(rdata, expq.pop_front());
      rd_d <= rd_s;
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      pin = 1'b0;
      rd_d = 1'b0;
      for (i = 0; i < 3; i++) begin
         do_reset();
         wr(8'hf2, 8'h00);
         wr(8'h0c, i[7:0]);
         repeat ((1600 >> i) - 60) @(negedge clk);
         check({7'h00, pwm[0]}, 8'h01);
         repeat (110) @(negedge clk);
         check({7'h00, pwm[0]}, 8'h00);
      end
      do_reset();
      rd(8'h03, {6'h00, pin, 1'b1});
      for (i = 0; i < 10; i++) rd(ra[i], rv[i]);
      wr(8'hf2, 8'h00);
      lvl_is(0, 1'b1);
      wr(8'h0c, 8'h0b);
      lvl_is(0, 1'b0);
      for (i = 0; i < 4; i++) begin
         wr(wa[i], 8'hff);
         rd(wa[i], (i == 3) ? 8'h0f : 8'h03);
      end
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h00);
      wr(8'h55, 8'hff);
      rd(8'h55, 8'h00);
      for (i = 0; i < 2; i++) begin
         d = 8'(rnd());
         wr(8'h78 + i[7:0], d);
         rd(8'h78 + i[7:0], d);
      end
      // No oscillator tick fits between fast edges, so the count stays 0
      wr(8'h68, 8'hff);
      repeat (200) @(posedge clk);
      rd(8'h70, 8'h00);
      wr(8'h09, 8'h00);
      wr(8'h07, 8'h00);
      wr(8'hf1, 8'h0c);
      wr(8'h69, 8'h2f);
      wr(8'h03, 8'h01);
      lvl_is(0, 1'b1);
      lvl_is(1, 1'b0);
      wr(8'h07, 8'h01);
      lvl_is(0, 1'b0);
      wr(8'h07, 8'h00);
      rd(8'hf0, 8'h08);
      lvl_is(2, 1'b1);
      wr(8'hf1, 8'h00);
      lvl_is(2, 1'b0);
      wr(8'hf0, 8'h08);
      wr(8'hf1, 8'h0c);
      lvl_is(2, 1'b0);
      wr(8'hf2, 8'h0f);
      wr(8'h03, 8'h03);
      lvl_is(1, 1'b1);
      wr(8'h07, 8'h01);
      wr(8'h09, 8'h01);
      lvl_is(0, 1'b1);
      wr(8'h09, 8'h00);
      wr(8'h07, 8'h00);
      wr(8'h03, 8'h02);
      lvl_is(2, 1'b1);
      lvl_is(0, 1'b0);
      rd(8'hf0, 8'h04);
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule // tb
`default_nettype wire
